// file: rtl/tfs_pkg.sv
// Purpose: Shared constants and types of the thermal fault supervisor
// Assumes: 50 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package tfs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  TFS_OFS_CONFIG     = 8'h00;
    localparam logic [7:0]  TFS_OFS_DISCHARGE  = 8'h04;
    localparam logic [7:0]  TFS_OFS_TEMP_GROUP = 8'h08;
    localparam logic [7:0]  TFS_OFS_CONVERT    = 8'h0c;
    localparam logic [7:0]  TFS_OFS_STATUS     = 8'h10;
    localparam logic [7:0]  TFS_OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0]  TFS_OFS_CELL_DATA  = 8'h18;
    localparam logic [7:0]  TFS_OFS_KICK       = 8'h1c;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          TFS_BIT_CONV_EN    = 0;
    localparam int          TFS_BIT_TEN_CELL   = 1;
    localparam int          TFS_BIT_GPO_ONE    = 2;
    localparam int          TFS_BIT_GPO_TWO    = 3;
    localparam int          TFS_BIT_ALL_CELLS  = 4;
    localparam int          TFS_BIT_SHUTDOWN   = 0;
    localparam int          TFS_BIT_STANDBY    = 1;
    localparam int          TFS_BIT_CONV_DONE  = 2;
    localparam int          TFS_CELLS          = 12;
    localparam int          TFS_TEN            = 10;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  TFS_CONFIG_RST     = 4'hc;
    localparam logic [11:0] TFS_DISCH_RST      = 12'h000;
    localparam logic [2:0]  TFS_MASK_RST       = 3'h0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint      TFS_CLK_HZ         = 64'd50000000;
    localparam longint      TFS_LINK_LOSS_S    = 64'd2;
    localparam int          TFS_LINK_LOSS_CYC  = int'(TFS_LINK_LOSS_S * TFS_CLK_HZ);
    localparam int          TFS_CONV_CYC       = 16;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TFS_CV_IDLE,
        TFS_CV_RUN,
        TFS_CV_DONE
    } tfs_conv_state_t;
endpackage

// file: rtl/tfs_sync_if.sv
// Purpose: Carrier of synchronised pin levels between supervisor modules
// Assumes: One clock domain
// Notes:   Source is the input synchroniser, sink is the supervisor top
`timescale 1ns/100ps
`default_nettype none
interface tfs_sync_if;
    logic hot;
    logic cur_active;
    logic link_act;
    modport src (output hot, output cur_active, output link_act);
    modport dst (input hot, input cur_active, input link_act);
endinterface
`default_nettype wire

// file: rtl/tfs_pin_sync.sv
// Purpose: Three-stage synchroniser for one asynchronous pin
// Assumes: Synchronous active-low reset
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module tfs_pin_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output var  logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } tfs_sync_st_t;
    tfs_sync_st_t st_r;
    tfs_sync_st_t st_nxt;
    always_comb begin
        st_nxt     = st_r;
        st_nxt.s1  = pin;
        st_nxt.s2  = st_r.s1;
        st_nxt.s3  = st_r.s2;
        // Stage one feeds stage two only, to keep metastability contained
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign level = st_r.lvl;
endmodule
`default_nettype wire

// file: rtl/tfs_supervisor.sv
// Purpose: Thermal shutdown, link-loss standby and cell selection supervisor
// Assumes: APB master on sys_clk; comparator and link pins asynchronous
// Notes:   Analog sensing is outside; hot pin is the 145 C comparator output
//
// Functional notes
// [R01] Over-temperature watch runs whenever the device is not in standby.
// [R02] Watch also runs in standby while any current-mode pin conducts.
// [R03] Overheat resets configuration, turning discharge off and stopping conversions.
// [R04] Overheat sets the thermal shutdown flag in the temperature group.
// [R05] Reading the temperature group clears the thermal shutdown flag.
// [R06] Flag stays set after cooling until the temperature group read.
// [R07] Link silence enters standby within two seconds.
// [R08] Standby forces every discharge output off.
// [R09] Standby entry drives watchdog_timeout_n low.
// [R10] All-cell conversion covers ten or twelve cells per ten_cell_select.
// [R11] A conversion may measure one selected cell only.
// [R12] Unused channels tied to the top input report zero volts.
// [R13] Twelve discharge outputs, one per cell, usable as gate drives.
// [R14] Host selects one of four probes via the two general outputs.
// [R15] General outputs default high while in shutdown.
// [R16] Host should watch internal temperature before shutdown threshold.

`timescale 1ns/100ps
`default_nettype none

module tfs_supervisor
    import tfs_pkg::*;
#(
    parameter int LINK_LOSS_CYC = tfs_pkg::TFS_LINK_LOSS_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        die_hot,
    input  wire logic        current_mode_active,
    input  wire logic        link_activity,
    input  wire logic [11:0] cell_unused,
    output var  logic [11:0] cell_discharge_output,
    output var  logic        general_output_one,
    output var  logic        general_output_two,
    output var  logic        watchdog_timeout_n,
    output var  logic        irq
);

    import tfs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // A few cycles of latency cost nothing next to thermal time constants
    tfs_sync_if sync_bus ();

    tfs_pin_sync u_sync_hot (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin     (die_hot),
        .level   (sync_bus.hot)
    );

    tfs_pin_sync u_sync_cur (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin     (current_mode_active),
        .level   (sync_bus.cur_active)
    );

    tfs_pin_sync u_sync_link (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin     (link_activity),
        .level   (sync_bus.link_act)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // One struct, so reset and update can never drift apart
    typedef struct packed {
        // Configuration, returned to defaults on overheat
        logic            conv_en;
        logic            ten_cell;
        logic            gpo_one;
        logic            gpo_two;
        logic [11:0]     discharge;
        // Sticky flags and link watchdog
        logic            shutdown_flag;
        logic            standby;
        logic [31:0]     idle_cnt;
        logic            link_prev;
        logic [2:0]      status;
        logic [2:0]      mask;
        // Conversion sequencer
        tfs_conv_state_t cv_state;
        logic [4:0]      cv_cnt;
        logic            cv_all;
        logic [3:0]      cv_cell;
        logic [11:0]     cv_result;
        // Read word captured in the setup cycle
        logic [31:0]     rdata;
    } tfs_st_t;

    tfs_st_t st_r;
    tfs_st_t st_nxt;

    logic    wr_acc;
    logic    rd_acc;
    logic    watch_on;
    logic    overheat;
    logic    link_edge;
    logic    mapped;
    logic [11:0] cell_mask;

    // Access-phase strobes; with pready tied high each access is one cycle
    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && penable && !pwrite;
    // Watch runs outside standby, or in standby while a current-mode pin conducts
    assign watch_on  = !st_r.standby || sync_bus.cur_active; // [R01] [R02]
    assign overheat  = watch_on && sync_bus.hot;
    assign link_edge = sync_bus.link_act != st_r.link_prev;
    // Unaligned or out-of-range offsets answer with pslverr
    assign mapped    = (paddr[1:0] == 2'b00) && (paddr <= TFS_OFS_KICK);
    // Ten-cell mode limits all-cell conversions to cells one to ten
    assign cell_mask = st_r.ten_cell ? 12'h3ff : 12'hfff; // [R10]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.link_prev = sync_bus.link_act;

        // Register writes
        if (wr_acc) begin
            unique case (paddr)
                TFS_OFS_CONFIG: begin
                    st_nxt.conv_en  = pwdata[TFS_BIT_CONV_EN];
                    st_nxt.ten_cell = pwdata[TFS_BIT_TEN_CELL];
                    // Host steers the probe multiplexer through these two bits
                    st_nxt.gpo_one  = pwdata[TFS_BIT_GPO_ONE];
                    st_nxt.gpo_two  = pwdata[TFS_BIT_GPO_TWO];
                end
                TFS_OFS_DISCHARGE: begin
                    st_nxt.discharge = pwdata[11:0];
                end
                TFS_OFS_IRQ_MASK: begin
                    st_nxt.mask = pwdata[2:0];
                end
                TFS_OFS_CONVERT: begin
                    // A start while busy, disabled or in standby is dropped
                    if (st_r.conv_en && st_r.cv_state == TFS_CV_IDLE && !st_r.standby) begin
                        st_nxt.cv_state = TFS_CV_RUN;
                        st_nxt.cv_cnt   = 5'h00;
                        st_nxt.cv_all   = pwdata[TFS_BIT_ALL_CELLS];
                        st_nxt.cv_cell  = pwdata[3:0]; // [R11]
                    end
                end
                default: begin
                end
            endcase
        end

        // Link watchdog: any access or pin activity restarts the count
        // The count saturates, so a long silence never wraps to zero
        if (link_edge || (psel && penable)) begin
            st_nxt.idle_cnt = 32'h0;
            st_nxt.standby  = 1'b0;
        end else if (st_r.idle_cnt >= 32'(LINK_LOSS_CYC - 1)) begin
            if (!st_r.standby) begin
                st_nxt.status[TFS_BIT_STANDBY] = 1'b1;
            end
            st_nxt.standby = 1'b1; // [R07]
        end else begin
            st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
        end

        // Conversion sequencer
        unique case (st_r.cv_state)
            TFS_CV_IDLE: begin
            end
            TFS_CV_RUN: begin
                st_nxt.cv_cnt = st_r.cv_cnt + 5'h01;
                if (st_r.cv_cnt == 5'(TFS_CONV_CYC - 1)) begin
                    st_nxt.cv_state = TFS_CV_DONE;
                    if (st_r.cv_all) begin
                        // Unused channels tied to the top input read as zero
                        st_nxt.cv_result = cell_mask & ~cell_unused; // [R12]
                    end else begin
                        st_nxt.cv_result = 12'h000;
                        if (32'(st_r.cv_cell) < TFS_CELLS) begin
                            st_nxt.cv_result[st_r.cv_cell] = ~cell_unused[st_r.cv_cell];
                        end
                    end
                end
            end
            TFS_CV_DONE: begin
                st_nxt.cv_state = TFS_CV_IDLE;
                st_nxt.status[TFS_BIT_CONV_DONE] = 1'b1;
            end
            // The fourth code is unreachable; fall back to idle
            default: begin
                st_nxt.cv_state = TFS_CV_IDLE;
            end
        endcase

        // Read data and read side effects; set below still wins
        // Loaded in setup so prdata stands through the access cycle
        st_nxt.rdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                TFS_OFS_CONFIG:     st_nxt.rdata = {28'h0, st_r.gpo_two, st_r.gpo_one, st_r.ten_cell, st_r.conv_en};
                TFS_OFS_DISCHARGE:  st_nxt.rdata = {20'h0, st_r.discharge};
                TFS_OFS_TEMP_GROUP: st_nxt.rdata = {31'h0, st_r.shutdown_flag};
                TFS_OFS_CONVERT:    st_nxt.rdata = {30'h0, st_r.cv_state != TFS_CV_IDLE, st_r.standby};
                TFS_OFS_STATUS:     st_nxt.rdata = {29'h0, st_r.status};
                TFS_OFS_IRQ_MASK:   st_nxt.rdata = {29'h0, st_r.mask};
                TFS_OFS_CELL_DATA:  st_nxt.rdata = {20'h0, st_r.cv_result};
                default:            st_nxt.rdata = 32'h0;
            endcase
        end

        // Clears at the access edge, the edge that hands over the data
        if (rd_acc && paddr == TFS_OFS_TEMP_GROUP) begin
            st_nxt.shutdown_flag = 1'b0; // [R05]
        end

        // Events landing in the clearing cycle are kept
        if (rd_acc && paddr == TFS_OFS_STATUS) begin
            st_nxt.status = 3'h0;
            if (st_r.cv_state == TFS_CV_DONE) begin
                st_nxt.status[TFS_BIT_CONV_DONE] = 1'b1;
            end
            if (!st_r.standby && st_nxt.standby) begin
                st_nxt.status[TFS_BIT_STANDBY] = 1'b1;
            end
        end

        // Thermal shutdown overrides writes; flag holds after cooling
        // Placed last so it beats a same-cycle write or flag clear
        if (overheat) begin
            st_nxt.conv_en       = TFS_CONFIG_RST[TFS_BIT_CONV_EN]; // [R03]
            st_nxt.ten_cell      = TFS_CONFIG_RST[TFS_BIT_TEN_CELL];
            st_nxt.gpo_one       = TFS_CONFIG_RST[TFS_BIT_GPO_ONE]; // [R15]
            st_nxt.gpo_two       = TFS_CONFIG_RST[TFS_BIT_GPO_TWO];
            st_nxt.discharge     = TFS_DISCH_RST;
            st_nxt.cv_state      = TFS_CV_IDLE;
            st_nxt.shutdown_flag = 1'b1; // [R04] [R06]
            st_nxt.status[TFS_BIT_SHUTDOWN] = 1'b1;
        end
    end

    // Synchronous reset; configuration fields take their defaults
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.conv_en   <= TFS_CONFIG_RST[TFS_BIT_CONV_EN];
            st_r.ten_cell  <= TFS_CONFIG_RST[TFS_BIT_TEN_CELL];
            st_r.gpo_one   <= TFS_CONFIG_RST[TFS_BIT_GPO_ONE];
            st_r.gpo_two   <= TFS_CONFIG_RST[TFS_BIT_GPO_TWO];
            st_r.discharge <= TFS_DISCH_RST;
            st_r.mask      <= TFS_MASK_RST;
            st_r.cv_state  <= TFS_CV_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata                = st_r.rdata;
    // No wait states: read words are already in flops at access
    assign pready                = 1'b1;
    assign pslverr               = psel && penable && !mapped;
    // Gate drives are forced off in standby regardless of configuration
    assign cell_discharge_output = st_r.standby ? 12'h000 : st_r.discharge; // [R08] [R13]
    assign general_output_one    = st_r.gpo_one;
    assign general_output_two    = st_r.gpo_two;
    // Low for the whole of standby, so the far side can drop its loads
    assign watchdog_timeout_n    = !st_r.standby; // [R09]
    // Level interrupt; a status read drops it
    assign irq                   = |(st_r.status & st_r.mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_standby_discharge_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R08]
        st_r.standby |-> cell_discharge_output == 12'h000)
        else $error("discharge active in standby");

    a_standby_signal: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R09]
        $rose(st_r.standby) |-> !watchdog_timeout_n)
        else $error("watchdog output not low in standby");

    a_overheat_config: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R03]
        overheat |=> st_r.discharge == TFS_DISCH_RST && !st_r.conv_en)
        else $error("config not reset on overheat");

    a_overheat_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R04]
        overheat |=> st_r.shutdown_flag)
        else $error("shutdown flag not set");

    a_flag_clear_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R05]
        rd_acc && paddr == TFS_OFS_TEMP_GROUP && !overheat |=> !st_r.shutdown_flag)
        else $error("flag not cleared by read");

    a_flag_holds: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R06]
        st_r.shutdown_flag && !(rd_acc && paddr == TFS_OFS_TEMP_GROUP) |=> st_r.shutdown_flag)
        else $error("flag dropped without read");

    a_watch_active: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R01] [R02]
        sync_bus.hot && (!st_r.standby || sync_bus.cur_active) |=> st_r.shutdown_flag)
        else $error("overheat missed while watch active");

    a_gpo_shutdown_high: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
        overheat |=> general_output_one && general_output_two)
        else $error("general outputs not high after shutdown");

    a_link_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R07]
        st_r.idle_cnt >= 32'(LINK_LOSS_CYC - 1) && !link_edge && !(psel && penable) |=> st_r.standby)
        else $error("standby not entered on link loss");

    a_ten_cell_mask: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
        st_r.cv_all && st_r.ten_cell && st_r.cv_state == TFS_CV_DONE |-> st_r.cv_result[11:10] == 2'b00)
        else $error("ten-cell result covers cells eleven and twelve");

    a_one_cell_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
        st_r.cv_state == TFS_CV_DONE && !st_r.cv_all |-> (st_r.cv_result & ~(12'h001 << st_r.cv_cell)) == 12'h000)
        else $error("single-cell result shows another channel");

    a_unused_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R12]
        st_r.cv_state == TFS_CV_DONE |-> (st_r.cv_result & cell_unused) == 12'h000)
        else $error("unused channel reads nonzero");

    a_overheat_stops_conv: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R03]
        overheat |=> st_r.cv_state == TFS_CV_IDLE)
        else $error("conversion not stopped on overheat");

endmodule

`default_nettype wire

// file: sim/tfs_host_model.sv
// Purpose: Host processor model, APB master in front of the supervisor
// Assumes: One clock, master changes signals right after a rising edge
// Notes:   Reads note their expectation in queues before the transfer starts
`timescale 1ns/100ps
`default_nettype none
module tfs_host_model
    import tfs_pkg::*;
(
    input  wire logic        sys_clk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic        pready
);
    logic [31:0] data_q[$];
    logic [31:0] mask_q[$];
    logic        err_q[$];
    string       name_q[$];
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // No local limit on the wait: only the bench watchdog may end it
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic read(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic e, input string n);
        data_q.push_back(d & m);
        mask_q.push_back(m);
        err_q.push_back(e);
        name_q.push_back(n);
        xfer(1'b0, a, 32'h0);
    endtask
    // ------------------------------------------------------------
    // Host duties
    // ------------------------------------------------------------
    // Probe channel code goes out on the two general outputs
    task automatic select_probe(input logic [1:0] ch, input logic [31:0] base);
        write(TFS_OFS_CONFIG, (base & 32'hfffffff3) | {28'h0, ch, 2'b00});
    endtask
    task automatic poll_temp(input logic exp);
        read(TFS_OFS_TEMP_GROUP, {31'h0, exp}, 32'h1, 1'b0, "temp_group");
    endtask
endmodule
`default_nettype wire

// file: sim/tfs_supervisor_tb_top.sv
// Purpose: Self-checking bench of the thermal fault supervisor
// Assumes: Host model drives APB, bench drives pins and link activity
// Notes:   Link loss shortened to LOSS cycles to keep the run short
`timescale 1ns/100ps
`default_nettype none
module tfs_supervisor_tb_top;
    import tfs_pkg::*;
    localparam int LOSS = 60;
    logic        sys_clk = 1'b0, rst_n = 1'b0, pready, pslverr, die_hot = 1'b0, cma = 1'b0;
    logic        link_activity = 1'b0, link_on = 1'b1, gpo1, gpo2, wdt_n, irq;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [11:0] cell_unused = 12'h0, dis;
    logic [2:0]  lk_cnt = 3'h0;
    int          mismatches = 0, tests_run = 0, seed = 25707;
    tfs_supervisor #(.LINK_LOSS_CYC(LOSS)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .die_hot(die_hot), .current_mode_active(cma), .link_activity(link_activity),
        .cell_unused(cell_unused), .cell_discharge_output(dis), .general_output_one(gpo1),
        .general_output_two(gpo2), .watchdog_timeout_n(wdt_n), .irq(irq));
    tfs_host_model host (
        .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready));
    always #10 sys_clk = ~sys_clk;
    // Slow toggles so the synchroniser sees each level settle
    always @(posedge sys_clk) begin
        lk_cnt <= lk_cnt + 3'h1;
        if (link_on && lk_cnt == 3'h0) link_activity <= ~link_activity;
    end
    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && host.name_q.size() > 0) begin
            check(host.name_q[0], prdata & host.mask_q[0], host.data_q.pop_front());
            check({host.name_q.pop_front(), "_err"}, pslverr, host.err_q.pop_front());
            void'(host.mask_q.pop_front());
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wait_standby();
        int n;
        n = 0;
        while (wdt_n !== 1'b0 && n < LOSS + 10) begin
            n++;
            cyc(1);
        end
        check("watchdog_timeout_n", wdt_n, 32'h0);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        cyc(20000);
        mismatches++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int k;
        cyc(4);
        rst_n <= 1'b1;
        host.read(TFS_OFS_CONFIG, 32'hc, 32'hf, 1'b0, "config_rst");
        host.read(TFS_OFS_DISCHARGE, 32'h0, 32'hfff, 1'b0, "disch_rst");
        host.read(8'h20, 32'h0, 32'hffffffff, 1'b1, "unmapped");
        check("gpo_pins", {gpo2, gpo1}, 32'h3);
        $display("test reset done");
        for (int ch = 0; ch < 4; ch++) begin
            host.select_probe(2'(ch), 32'h0);
            cyc(1);
            check("probe_sel", {gpo2, gpo1}, 32'(ch));
            r = $random(seed);
            host.write(TFS_OFS_DISCHARGE, {20'h0, r[11:0]});
            cyc(1);
            check("discharge", dis, {20'h0, r[11:0]});
        end
        $display("test outputs done");
        for (int t = 0; t < 2; t++) begin
            r = $random(seed);
            cell_unused <= r[11:0];
            host.write(TFS_OFS_CONFIG, t == 0 ? 32'hf : 32'hd);
            host.write(TFS_OFS_CONVERT, 32'h10);
            cyc(20);
            host.read(TFS_OFS_STATUS, 32'h4, 32'h4, 1'b0, "conv_done");
            host.read(TFS_OFS_CELL_DATA, {20'h0, ~r[11:0]} & (t == 0 ? 32'h3ff : 32'hfff),
                      32'hfff, 1'b0, "all_cells");
            k = (r[30:16] % 12);
            host.write(TFS_OFS_CONVERT, 32'(k));
            cyc(20);
            host.read(TFS_OFS_CELL_DATA, {20'h0, ~r[11:0]}, 32'h1 << k, 1'b0, "one_cell");
        end
        $display("test conversion done");
        host.write(TFS_OFS_IRQ_MASK, 32'h1);
        host.write(TFS_OFS_CONFIG, 32'hb);
        host.write(TFS_OFS_DISCHARGE, 32'h5a5);
        die_hot <= 1'b1;
        cyc(8);
        check("disch_hot", dis, 32'h0);
        check("gpo_hot", {gpo2, gpo1}, 32'h3);
        check("irq_hot", irq, 32'h1);
        die_hot <= 1'b0;
        cyc(8);
        host.poll_temp(1'b1);
        host.poll_temp(1'b0);
        host.read(TFS_OFS_CONFIG, 32'hc, 32'hf, 1'b0, "config_hot");
        host.read(TFS_OFS_STATUS, 32'h1, 32'h1, 1'b0, "status_hot");
        cyc(1);
        check("irq_clear", irq, 32'h0);
        $display("test thermal done");
        host.write(TFS_OFS_IRQ_MASK, 32'h2);
        host.write(TFS_OFS_DISCHARGE, 32'hfff);
        link_on <= 1'b0;
        wait_standby();
        check("disch_standby", dis, 32'h0);
        check("irq_standby", irq, 32'h1);
        die_hot <= 1'b1;
        cyc(8);
        die_hot <= 1'b0;
        cyc(8);
        host.poll_temp(1'b0);
        wait_standby();
        cma <= 1'b1;
        die_hot <= 1'b1;
        cyc(8);
        die_hot <= 1'b0;
        cma <= 1'b0;
        cyc(8);
        link_on <= 1'b1;
        host.poll_temp(1'b1);
        host.read(TFS_OFS_STATUS, 32'h2, 32'h2, 1'b0, "status_standby");
        cyc(6);
        check("watchdog_exit", wdt_n, 32'h1);
        $display("test standby done");
        wrap_up();
    end
endmodule
`default_nettype wire
